// >>> rtl/swmc_pkg.sv
/*
 * Shared constants and types of the sleep and wake mode control block.
 * Assumes a single 200 MHz clock domain and plain-port configuration.
 */
package swmc_pkg;
	localparam int NUM_RES = 13;
	localparam int NUM_STEPS = 8;
	localparam int DLY_W = 8;
	localparam int CLK_MHZ = 200;
	localparam logic [2:0] POL_RESET = 3'h0;
	localparam logic SLEEP_MASK_RESET = 1'h1;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ACTIVE,
		ST_TO_SLEEP,
		ST_SLEEP,
		ST_TO_ACTIVE,
		ST_TO_OFF
	} pwr_state_t;

	typedef enum logic [1:0] {
		SEQ_NONE,
		SEQ_ACTIVE_TO_SLEEP_SEQ,
		SEQ_SLEEP_TO_ACTIVE_SEQ,
		SEQ_SLEEP_TO_OFF_SEQ
	} seq_sel_t;

	typedef struct packed {
		logic sleep_inv;
		logic ctrl_a_inv;
		logic ctrl_b_inv;
	} pin_polarity_t;

	typedef struct packed {
		logic [NUM_RES-1:0] sleep_pin;
		logic [NUM_RES-1:0] ctrl_a;
		logic [NUM_RES-1:0] ctrl_b;
	} assign_t;

	typedef struct packed {
		logic [$clog2(NUM_RES)-1:0] res;
		logic [DLY_W-1:0] delay;
	} seq_step_t;
endpackage

// >>> rtl/sleep_wake_mode_control.sv
/*
 * Sleep and wake state control with per-resource power mode selection.
 * Assumes the host drives the three control pins asynchronously and that
 * the stored sequence steps and assignments are static while used.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Accepted sleep request in ACTIVE moves to SLEEP, resources take low-power modes.
// - Sleep sequence starts only with no unmasked interrupt pending.
// - In SLEEP only an interrupt or the sleep pin can wake.
// - Wake acts only in SLEEP and starts wake-to-active or sleep-to-off.
// - Sleep pin is the only, level, active-low, maskable source; masked at reset.
// - Sleep-pin-only resources change mode only through the running sequence.
// - Direct-control resources switch mode immediately when their pin changes.
// - Unassigned resources stay in ACTIVE mode always.
// - Multiple pins: sleep only when all assigned pins are at sleep level.
// - Direct-control pins default active high.
// - Sleep pin defaults active low.
// - Each pin polarity is independently invertible.
// - Per-resource assignment bits exist for each control pin.
// - Resources on one direct pin switch together in one cycle.
// - Sleep-pin-only resources switch in stored sequence order.
// - Sequence sets the sleep state of the listed resources stepwise.
// - Stored delay is inserted between consecutive steps.
// - Resources in no sequence stay off until software enables them after it.
// - Active and sleep modes come from each resource's mode registers.
// - Off request overrides pending sleep or wake without gating.
module sleep_wake_mode_control
	import swmc_pkg::*;
#(
	parameter int N = swmc_pkg::NUM_RES,
	parameter int STEPS = swmc_pkg::NUM_STEPS
)(
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control pins from the host.
	input wire logic sleep_request_pin,
	input wire logic direct_mode_ctrl_a,
	input wire logic direct_mode_ctrl_b,
	// Configuration.
	input wire swmc_pkg::pin_polarity_t pin_polarity_config,
	input wire logic sleep_unmask,
	input wire swmc_pkg::assign_t assignment,
	input wire logic [N-1:0] seq_member,
	input wire logic [N-1:0] sw_enable,
	input wire logic [N-1:0] active_mode_cfg,
	input wire logic [N-1:0] sleep_mode_cfg,
	input wire swmc_pkg::seq_step_t [STEPS-1:0] sleep_steps,
	input wire logic [$clog2(STEPS+1)-1:0] sleep_step_count,
	// Events.
	input wire logic power_on,
	input wire logic off_request,
	input wire logic irq_pending,
	input wire logic wake_to_off,
	// Status and resource control.
	output logic [N-1:0] res_enable,
	output logic [N-1:0] res_mode,
	output logic [N-1:0] res_asleep,
	output swmc_pkg::pwr_state_t pwr_state,
	output logic seq_busy
);
	import swmc_pkg::*;

	logic [SYNC_STAGES-1:0] sync_s;
	logic [SYNC_STAGES-1:0] sync_a;
	logic [SYNC_STAGES-1:0] sync_b;
	logic lvl_s;
	logic lvl_a;
	logic lvl_b;
	logic sleep_lvl;
	logic a_sleep;
	logic b_sleep;
	logic [N-1:0] want_sleep;
	logic [N-1:0] seq_sleep;
	logic [N-1:0] direct_only;
	logic [N-1:0] sleep_pin_res;
	logic [$clog2(STEPS+1)-1:0] step;
	logic [DLY_W-1:0] wait_cnt;
	logic seq_done;
	logic sleep_req;
	logic sleep_unmasked;
	logic [N-1:0] next_asleep;

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_s <= '1;
			sync_a <= '1;
			sync_b <= '1;
		end
		else if (ce)
		begin
			sync_s <= {sync_s[SYNC_STAGES-2:0], sleep_request_pin};
			sync_a <= {sync_a[SYNC_STAGES-2:0], direct_mode_ctrl_a};
			sync_b <= {sync_b[SYNC_STAGES-2:0], direct_mode_ctrl_b};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_s <= 1'h1;
			lvl_a <= 1'h1;
			lvl_b <= 1'h1;
		end
		else if (ce)
		begin
			if (sync_s[1] == sync_s[2])
				lvl_s <= sync_s[2];
			if (sync_a[1] == sync_a[2])
				lvl_a <= sync_a[2];
			if (sync_b[1] == sync_b[2])
				lvl_b <= sync_b[2];
		end
	end

	// The sleep pin comes out of reset masked until software unmasks it.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sleep_unmasked <= ~SLEEP_MASK_RESET;
		else if (ce)
			sleep_unmasked <= sleep_unmask;
	end

	// Sleep levels: sleep pin active low, direct pins active high by default.
	assign sleep_lvl = lvl_s ^ pin_polarity_config.sleep_inv;
	assign a_sleep = ~(lvl_a ^ pin_polarity_config.ctrl_a_inv);
	assign b_sleep = ~(lvl_b ^ pin_polarity_config.ctrl_b_inv);
	assign sleep_req = ~sleep_lvl & sleep_unmasked;

	assign sleep_pin_res = assignment.sleep_pin;
	assign direct_only = (assignment.ctrl_a | assignment.ctrl_b) &
		~assignment.sleep_pin;

	// A resource sleeps only when every assigned pin is at its sleep level.
	always_comb
	begin
		want_sleep = '0;
		for (int i = 0; i < N; i++)
		begin
			if (assignment.sleep_pin[i] | assignment.ctrl_a[i] |
				assignment.ctrl_b[i])
				want_sleep[i] = (~assignment.ctrl_a[i] | a_sleep) &
					(~assignment.ctrl_b[i] | b_sleep) &
					(~assignment.sleep_pin[i] | seq_sleep[i]);
		end
	end

	assign seq_done = (step >= sleep_step_count) && (wait_cnt == '0);

	// Power state machine.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pwr_state <= ST_OFF;
		else if (ce)
		begin
			if (off_request && pwr_state != ST_OFF)
				pwr_state <= ST_OFF;
			else
			begin
				unique case (pwr_state)
					ST_OFF:
						if (power_on)
							pwr_state <= ST_ACTIVE;
					ST_ACTIVE:
						if (sleep_req && !irq_pending)
							pwr_state <= ST_TO_SLEEP;
					ST_TO_SLEEP:
						if (seq_done)
							pwr_state <= ST_SLEEP;
					ST_SLEEP:
						if (irq_pending || !sleep_req)
							pwr_state <= wake_to_off ? ST_TO_OFF : ST_TO_ACTIVE;
					ST_TO_ACTIVE:
						if (seq_done)
							pwr_state <= ST_ACTIVE;
					ST_TO_OFF:
						if (seq_done)
							pwr_state <= ST_OFF;
				endcase
			end
		end
	end

	// Step walker: one resource per step, stored delay between steps.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			step <= '0;
			wait_cnt <= '0;
			seq_sleep <= '0;
		end
		else if (ce)
		begin
			if (pwr_state == ST_ACTIVE || pwr_state == ST_SLEEP ||
				pwr_state == ST_OFF)
			begin
				step <= '0;
				wait_cnt <= '0;
				if (pwr_state == ST_OFF)
					seq_sleep <= '0;
			end
			else if (wait_cnt != '0)
				wait_cnt <= wait_cnt - 1'b1;
			else if (step < sleep_step_count)
			begin
				seq_sleep[sleep_steps[step].res] <=
					(pwr_state == ST_TO_SLEEP);
				wait_cnt <= sleep_steps[step].delay;
				step <= step + 1'b1;
			end
		end
	end

	assign next_asleep = want_sleep & (sleep_pin_res | direct_only);

	// Resource outputs; direct pins update all their resources at once.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_asleep <= '0;
			res_mode <= '0;
			res_enable <= '0;
			seq_busy <= 1'h0;
		end
		else if (ce)
		begin
			res_asleep <= next_asleep;
			for (int i = 0; i < N; i++)
				res_mode[i] <= next_asleep[i] ? sleep_mode_cfg[i] :
					active_mode_cfg[i];
			if (pwr_state == ST_OFF)
				res_enable <= '0;
			else
				res_enable <= seq_member | (sw_enable & {N{~seq_busy}});
			seq_busy <= pwr_state == ST_TO_SLEEP ||
				pwr_state == ST_TO_ACTIVE || pwr_state == ST_TO_OFF;
		end
	end

	a_off_wins: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && off_request && pwr_state != ST_OFF) |=> pwr_state == ST_OFF)
		else $error("off request did not force OFF");
	a_irq_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && pwr_state == ST_ACTIVE && irq_pending && !off_request)
		|=> pwr_state == ST_ACTIVE)
		else $error("sleep started with pending interrupt");
	a_enter_sleep: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && pwr_state == ST_ACTIVE && sleep_req && !irq_pending &&
		!off_request) |=> pwr_state == ST_TO_SLEEP)
		else $error("accepted sleep request not started");
	a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && pwr_state == ST_SLEEP && !irq_pending && sleep_req &&
		!off_request) |=> pwr_state == ST_SLEEP)
		else $error("sleep left without wake source");
	a_wake_path: assert property (@(posedge clk) disable iff (!rst_n)
		(pwr_state == ST_TO_ACTIVE) |-> $past(pwr_state) inside
		{ST_SLEEP, ST_TO_ACTIVE})
		else $error("wake sequence outside sleep");
	a_unassigned: assert property (@(posedge clk) disable iff (!rst_n)
		(~(assignment.sleep_pin | assignment.ctrl_a | assignment.ctrl_b)
		& next_asleep) == '0)
		else $error("unassigned resource asleep");
	a_mode_sel: assert property (@(posedge clk) disable iff (!rst_n)
		ce ##1 (res_asleep == $past(next_asleep)) |->
		res_mode == ((res_asleep & $past(sleep_mode_cfg)) |
		(~res_asleep & $past(active_mode_cfg))))
		else $error("resource mode not from mode config");
	a_mask_reset: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !sleep_unmask) |=> !sleep_req)
		else $error("masked sleep pin requested sleep");
	a_off_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && pwr_state == ST_OFF) |=> res_enable == '0)
		else $error("resources enabled in OFF");
	a_busy_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && pwr_state == ST_TO_SLEEP) |=> seq_busy)
		else $error("sequence running without busy flag");
	a_direct_now: assert property (@(posedge clk) disable iff (!rst_n)
		ce |=> (((res_asleep ^ {N{$past(a_sleep)}}) &
		$past(assignment.ctrl_a & ~assignment.ctrl_b &
		~assignment.sleep_pin)) == '0))
		else $error("direct resources did not follow their pin");
	a_step_gap: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wait_cnt != '0 && pwr_state inside
		{ST_TO_SLEEP, ST_TO_ACTIVE, ST_TO_OFF}) |=> step == $past(step))
		else $error("step advanced during inter-step delay");
	a_wake_off: assert property (@(posedge clk) disable iff (!rst_n)
		(pwr_state == ST_TO_OFF) |-> $past(pwr_state) inside
		{ST_SLEEP, ST_TO_OFF})
		else $error("off sequence outside sleep");
endmodule
`default_nettype wire

// >>> bench/host_pins.sv
/*
 * Host side model: drives the sleep pin and both direct-control pins.
 * Assumes the bench calls drive and that pins move on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module host_pins (
	// Clock.
	input wire logic clk,
	// Control pins.
	output logic sleep_request_pin,
	output logic direct_mode_ctrl_a,
	output logic direct_mode_ctrl_b
);
	initial
	begin
		sleep_request_pin = 1'h1;
		direct_mode_ctrl_a = 1'h1;
		direct_mode_ctrl_b = 1'h1;
	end
	// The pins are pushed and held, so they never float.
	task automatic drive(input logic s, input logic a, input logic b);
		@(negedge clk);
		sleep_request_pin = s;
		direct_mode_ctrl_a = a;
		direct_mode_ctrl_b = b;
	endtask
endmodule
`default_nettype wire

// >>> bench/sleep_wake_mode_control_tb.sv
/*
 * Self-checking bench for the sleep and wake mode control block.
 * Assumes the host_pins model and the shared package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_mode_control_tb;
	import swmc_pkg::*;
	typedef struct packed {
		pwr_state_t st;
		logic [NUM_RES-1:0] asl;
	} note_t;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic sp, pa, pb, power_on, off_request, irq_pending, wake_to_off, unmask;
	pin_polarity_t pol;
	assign_t asg;
	seq_step_t [NUM_STEPS-1:0] steps;
	logic [NUM_RES-1:0] act, slp, sw_en, mem, res_enable, res_mode, res_asleep;
	pwr_state_t pwr_state;
	logic seq_busy;
	logic ce;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	int tn = 0;
	note_t notes[$];
	event shown;
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	host_pins host (.clk(clk), .sleep_request_pin(sp),
		.direct_mode_ctrl_a(pa), .direct_mode_ctrl_b(pb));
	sleep_wake_mode_control dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.sleep_request_pin(sp), .direct_mode_ctrl_a(pa),
		.direct_mode_ctrl_b(pb), .pin_polarity_config(pol),
		.sleep_unmask(unmask), .assignment(asg), .seq_member(mem),
		.sw_enable(sw_en), .active_mode_cfg(act), .sleep_mode_cfg(slp),
		.sleep_steps(steps), .sleep_step_count(4'h4), .power_on(power_on),
		.off_request(off_request), .irq_pending(irq_pending),
		.wake_to_off(wake_to_off), .res_enable(res_enable),
		.res_mode(res_mode), .res_asleep(res_asleep),
		.pwr_state(pwr_state), .seq_busy(seq_busy));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Waits a settle time, up to 300 cycles for the state, then two more.
	task automatic expect_out(input pwr_state_t st, input logic [12:0] a,
		input int settle);
		int n;
		n = 0;
		notes.push_back({st, a});
		repeat (settle) @(negedge clk);
		while ((pwr_state !== st || (st != ST_OFF && res_asleep !== a))
			&& n < 300)
		begin
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
		-> shown;
		@(negedge clk);
		$display("test %0d done", ++tn);
	endtask
	initial
	begin
		note_t e;
		logic [12:0] exp_en;
		forever
		begin
			@(shown);
			e = notes.pop_front();
			exp_en = (e.st == ST_OFF) ? 13'h0 : mem | sw_en;
			check({3'h0, res_enable}, {3'h0, exp_en});
			check({15'h0, seq_busy}, 16'h0);
			if (e.st == ST_OFF)
				check({pwr_state, 13'h0}, {e.st, 13'h0});
			else
			begin
				check({pwr_state, res_asleep}, e);
				check({3'h0, res_mode}, {3'h0, (e.asl & slp) | (~e.asl & act)});
			end
		end
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			conclude();
		end
	end
	initial
	begin
		void'($urandom(89));
		{power_on, off_request, irq_pending, wake_to_off, unmask} = 5'h0;
		ce = 1'h1;
		pol = POL_RESET;
		asg = {13'h03C0, 13'h020F, 13'h0030};
		steps = '0;
		for (int i = 0; i < 4; i++)
			steps[i] = '{res: 4'(6 + i), delay: 8'h02};
		act = 13'($urandom);
		slp = 13'($urandom);
		sw_en = 13'($urandom) & 13'h07FF;
		mem = 13'h01FF;
		repeat (4) @(negedge clk);
		rst_n = 1'h1;
		expect_out(ST_OFF, 13'h0, 1);
		power_on = 1'h1;
		expect_out(ST_ACTIVE, 13'h0, 1);
		power_on = 1'h0;
		ce = 1'h0;
		host.drive(1'h1, 1'h0, 1'h1);
		expect_out(ST_ACTIVE, 13'h0, 20);
		ce = 1'h1;
		host.drive(1'h1, 1'h0, 1'h1);
		expect_out(ST_ACTIVE, 13'h000F, 1);
		host.drive(1'h1, 1'h1, 1'h0);
		expect_out(ST_ACTIVE, 13'h0030, 1);
		pol.ctrl_a_inv = 1'h1;
		expect_out(ST_ACTIVE, 13'h003F, 1);
		pol = POL_RESET;
		host.drive(1'h0, 1'h1, 1'h1);
		expect_out(ST_ACTIVE, 13'h0, 40);
		unmask = 1'h1;
		irq_pending = 1'h1;
		expect_out(ST_ACTIVE, 13'h0, 40);
		irq_pending = 1'h0;
		expect_out(ST_SLEEP, 13'h01C0, 1);
		host.drive(1'h1, 1'h1, 1'h1);
		expect_out(ST_ACTIVE, 13'h0, 1);
		host.drive(1'h0, 1'h0, 1'h1);
		expect_out(ST_SLEEP, 13'h03CF, 1);
		wake_to_off = 1'h1;
		irq_pending = 1'h1;
		expect_out(ST_OFF, 13'h0, 1);
		{irq_pending, wake_to_off} = 2'h0;
		host.drive(1'h1, 1'h1, 1'h1);
		repeat (6) @(negedge clk);
		power_on = 1'h1;
		expect_out(ST_ACTIVE, 13'h0, 1);
		power_on = 1'h0;
		off_request = 1'h1;
		expect_out(ST_OFF, 13'h0, 1);
		conclude();
	end
endmodule
`default_nettype wire
